// File: rtl/bfb_top.sv
// Filter, decimation, offset correction and bias estimator block with its byte-frame register port.
// Behaviour
// [R1] Two cascaded averaging stages, same tap count.
// [R2] Filter size 0..6, two to that taps.
// [R3] Bias exponent 0..6, record two^(exp+11) samples.
// [R4] Filter control reads 0x0500 after reset.
// [R5] Gyro offsets: 16-bit two's complement corrections.
// [R6] Each offset added to its output data.
// [R7] Accel x offset: 16-bit two's complement.
// [R8] Accel y/z offsets: low 14 bits only.
// [R9] Command bit zero loads gyro offsets from estimator.
// [R10] Estimator record length from bias exponent.
// [R11] Host keeps unit still through record time.
// [R12] Host writes negated, scaled bias manually.
// [R13] Host writes upper byte, then lower byte.
// [R14] Output rate divided by decimation plus one.
// [R15] Data ready suppressed while command executes.
// [R16] Stage outputs average of recent tap inputs.
module bfb_top
  import bfb_pkg::*;
(
  input  wire logic        i_ref_clk,     // 200 MHz clock
  input  wire logic        i_rst_b,       // Asynchronous reset, active low
  input  wire logic        i_frame_vld,   // Register frame strobe
  input  wire logic [15:0] i_frame,       // Write flag, address, data byte
  output logic             o_rd_vld,      // Read answer strobe
  output logic      [15:0] o_rd_data,     // Read answer word
  input  wire logic        i_sample_tick, // 2048 SPS sample strobe
  input  wire logic [15:0] i_gyro_x,      // Raw gyro x sample
  input  wire logic [15:0] i_gyro_y,      // Raw gyro y sample
  input  wire logic [15:0] i_gyro_z,      // Raw gyro z sample
  input  wire logic [15:0] i_accl_x,      // Raw accel x sample
  input  wire logic [15:0] i_accl_y,      // Raw accel y sample
  input  wire logic [15:0] i_accl_z,      // Raw accel z sample
  output logic      [15:0] o_gyro_x,      // Corrected gyro x
  output logic      [15:0] o_gyro_y,      // Corrected gyro y
  output logic      [15:0] o_gyro_z,      // Corrected gyro z
  output logic      [15:0] o_accl_x,      // Corrected accel x
  output logic      [15:0] o_accl_y,      // Corrected accel y
  output logic      [15:0] o_accl_z,      // Corrected accel z
  output logic             o_data_ready   // New output data pulse
);

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  wire             wr_en   = i_frame_vld & i_frame[15];
  wire             rd_en   = i_frame_vld & ~i_frame[15];
  wire [6:0]       addr    = i_frame[14:8];
  wire [7:0]       wdata   = i_frame[7:0];
  wire [6:0]       waddr   = {addr[6:1], 1'b0};
  wire             hi_byte = addr[0];                          // R13
  wire [2:0]       wfield  = (wdata[2:0] > FIELD_MAX) ? FIELD_MAX : wdata[2:0];
  wire             fltr_wr = wr_en & (waddr == FILT_CTRL_ADDR);
  wire             dec_wr  = wr_en & (waddr == DEC_SET_ADDR);
  wire             cmd_go  = wr_en & (addr == CMD_REG_ADDR) & wdata[CMD_BIAS_BIT];

  logic [15:0]      fltr_q;
  logic [10:0]      dec_q;
  logic [10:0]      dec_cnt_q;
  logic [15:0]      off_q [NCH];
  logic [15:0]      out_q [NCH];
  logic [15:0]      rd_mux;
  bfb_state_t       state_q;
  bfb_state_t       state_d;
  logic             dr_q;

  wire [2:0]       size  = fltr_q[SIZE_LSB +: 3];
  wire [2:0]       bte   = fltr_q[BTE_LSB +: 3];
  wire             busy  = (state_q != ST_IDLE);
  wire             load  = (state_q == ST_LOAD);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Out-of-range size and exponent values clamp to six, so the fields never hold seven.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fltr_q <= FLTR_RST;                                      // R4
    end else if (fltr_wr && hi_byte) begin
      fltr_q[BTE_LSB +: 3] <= wfield;                          // R3
    end else if (fltr_wr) begin
      fltr_q[SIZE_LSB +: 3] <= wfield;                         // R2
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dec_q <= DEC_RST;
    end else if (dec_wr && hi_byte) begin
      dec_q[10:8] <= wdata[DEC_HI_BITS-1:0];
    end else if (dec_wr) begin
      dec_q[7:0] <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Averaging filter
  // ---------------------------------------------------------------
  bfb_filt_if #(.NCH(NCH), .W(16)) u_fif ();

  assign u_fif.tick    = i_sample_tick;
  assign u_fif.size    = size;
  assign u_fif.clr     = fltr_wr & ~hi_byte & (wfield != size);
  assign u_fif.din[0]  = i_gyro_x;
  assign u_fif.din[1]  = i_gyro_y;
  assign u_fif.din[2]  = i_gyro_z;
  assign u_fif.din[3]  = i_accl_x;
  assign u_fif.din[4]  = i_accl_y;
  assign u_fif.din[5]  = i_accl_z;

  bfb_avg_filter #(.NCH(NCH), .W(16), .MAXB(6)) u_filt (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .f         (u_fif.filt)
  );

  // ---------------------------------------------------------------
  // Continuous bias estimator on the raw gyro samples
  // ---------------------------------------------------------------
  // Block averages over the record; the last complete record is the estimate, which keeps memory small.
  logic [EST_CNT_W-1:0] est_cnt_q;
  logic signed [15:0]   est_q [NGYRO];
  // The shift amount is five bits wide, since exponent plus base reaches seventeen.
  wire  [4:0]           est_shift = 5'(bte) + 5'(BTE_BASE);
  wire  [EST_CNT_W-1:0] est_len  = EST_CNT_W'(1) << est_shift; // R10
  wire                  est_wrap = i_sample_tick & (est_cnt_q >= est_len - 1'b1);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      est_cnt_q <= '0;
    end else if (i_sample_tick) begin
      est_cnt_q <= est_wrap ? '0 : est_cnt_q + 1'b1;           // R3
    end
  end

  for (genvar g = 0; g < NGYRO; g++) begin : g_est
    logic signed [EST_ACC_W-1:0] acc_q;
    wire  signed [EST_ACC_W-1:0] acc_nx = acc_q + EST_ACC_W'($signed(u_fif.din[g]));
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        acc_q    <= '0;
        est_q[g] <= '0;
      end else if (est_wrap) begin
        acc_q    <= '0;
        est_q[g] <= 16'(acc_nx >>> est_shift);                 // R10
      end else if (i_sample_tick) begin
        acc_q    <= acc_nx;
      end
    end
  end

  // ---------------------------------------------------------------
  // Offset registers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_off
    wire [6:0]  my_addr = GYRO_X_ADDR + 7'(2 * i);
    wire        hit     = wr_en & (waddr == my_addr);
    wire [15:0] mask    = (i >= 4) ? ACCL_YZ_MASK : 16'hffff;  // R8
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        off_q[i] <= OFF_RST;
      end else if (load && i < NGYRO) begin
        off_q[i] <= bfb_sat_neg(est_q[i % NGYRO]);             // R9
      end else if (hit && hi_byte) begin
        off_q[i][15:8] <= wdata & mask[15:8];                  // R5 R7
      end else if (hit) begin
        off_q[i][7:0] <= wdata;                                // R13
      end
    end
  end

  // ---------------------------------------------------------------
  // Decimation, correction and output registers
  // ---------------------------------------------------------------
  wire dec_hit = u_fif.dvalid & (dec_cnt_q >= dec_q);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dec_cnt_q <= '0;
    end else if (u_fif.dvalid) begin
      dec_cnt_q <= dec_hit ? '0 : dec_cnt_q + 1'b1;            // R14
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_out
    wire signed [15:0] off_ext = (i >= 4) ? {{2{off_q[i][13]}}, off_q[i][13:0]} : off_q[i]; // R8
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        out_q[i] <= '0;
      end else if (dec_hit) begin
        out_q[i] <= bfb_sat_add(u_fif.dout[i], off_ext);      // R6
      end
    end
  end

  assign o_gyro_x = out_q[0];
  assign o_gyro_y = out_q[1];
  assign o_gyro_z = out_q[2];
  assign o_accl_x = out_q[3];
  assign o_accl_y = out_q[4];
  assign o_accl_z = out_q[5];

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = cmd_go ? ST_LOAD : ST_IDLE;
      ST_LOAD: state_d = ST_WAIT;
      ST_WAIT: state_d = u_fif.dvalid ? ST_IDLE : ST_WAIT;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      dr_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      dr_q    <= dec_hit & ~busy;                              // R15
    end
  end

  assign o_data_ready = dr_q;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_comb begin
    case (waddr)
      FILT_CTRL_ADDR: rd_mux = fltr_q;
      DEC_SET_ADDR:   rd_mux = {5'h00, dec_q};
      CMD_REG_ADDR:   rd_mux = {15'h0000, busy};
      GYRO_X_ADDR:    rd_mux = off_q[0];
      GYRO_Y_ADDR:    rd_mux = off_q[1];
      GYRO_Z_ADDR:    rd_mux = off_q[2];
      ACCL_X_ADDR:    rd_mux = off_q[3];
      ACCL_Y_ADDR:    rd_mux = off_q[4];
      ACCL_Z_ADDR:    rd_mux = off_q[5];
      default:        rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_vld  <= 1'b0;
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_vld  <= rd_en;
      o_rd_data <= rd_en ? rd_mux : o_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_cmd_issue;
    (state_q == ST_IDLE) && cmd_go;
  endsequence

  sequence s_cmd_load;
    load ##1 (state_q == ST_WAIT);
  endsequence

  a_cmd_loads_gyro: assert property (s_cmd_issue ##1 s_cmd_load |-> // R9
    off_q[0] == bfb_sat_neg($past(est_q[0])))
    else $error("Bias command did not load the gyro x offset.");
  a_size_range: assert property (size <= FIELD_MAX) // R2
    else $error("Filter size field out of range.");
  a_bte_range: assert property (bte <= FIELD_MAX && fltr_q[15:11] == '0) // R3
    else $error("Bias exponent field out of range.");
  a_fltr_reserved: assert property (fltr_q[7:3] == '0) // R4
    else $error("Reserved filter control bits set.");
  a_accl_upper_zero: assert property (off_q[4][15:14] == 2'b00 && off_q[5][15:14] == 2'b00) // R8
    else $error("Unused accel offset bits set.");
  a_dr_quiet_busy: assert property (busy |=> !o_data_ready) // R15
    else $error("Data ready raised during a command.");
  a_dec_period: assert property ($rose(o_data_ready) |-> $past(dec_cnt_q) == $past(dec_q)) // R14
    else $error("Output update not at the decimation count.");
  a_offset_applied: assert property (dec_hit |=> // R6
    out_q[3] == bfb_sat_add($past(u_fif.dout[3]), $past(off_q[3])))
    else $error("Accel x output lacks its offset.");
  a_est_len: assert property (est_cnt_q < est_len || $changed(bte)) // R10
    else $error("Estimator count exceeds the record length.");
  a_write_hi_byte: assert property (wr_en && waddr == GYRO_Y_ADDR && hi_byte && !load |=> // R13
    off_q[1][15:8] == $past(wdata))
    else $error("Upper byte write missed the gyro y offset.");

endmodule // bfb_top

// File: rtl/bfb_pkg.sv
// Package with the register map, field layout, reset values and helpers of the filter and bias block.
package bfb_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses of the 16-bit registers)
  // ---------------------------------------------------------------
  localparam logic [6:0] DEC_SET_ADDR   = 7'h36;
  localparam logic [6:0] FILT_CTRL_ADDR = 7'h38;
  localparam logic [6:0] CMD_REG_ADDR   = 7'h3e;
  localparam logic [6:0] GYRO_X_ADDR    = 7'h40;
  localparam logic [6:0] GYRO_Y_ADDR    = 7'h42;
  localparam logic [6:0] GYRO_Z_ADDR    = 7'h44;
  localparam logic [6:0] ACCL_X_ADDR    = 7'h46;
  localparam logic [6:0] ACCL_Y_ADDR    = 7'h48;
  localparam logic [6:0] ACCL_Z_ADDR    = 7'h4a;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          SIZE_LSB      = 0;
  localparam int          BTE_LSB       = 8;
  localparam int          CMD_BIAS_BIT  = 0;
  localparam int          DEC_HI_BITS   = 3;
  localparam int          BTE_BASE      = 11;
  localparam logic [2:0]  FIELD_MAX     = 3'h6;
  localparam logic [15:0] FLTR_RST      = 16'h0500;
  localparam logic [15:0] OFF_RST       = 16'h0000;
  localparam logic [10:0] DEC_RST       = 11'h000;
  localparam logic [15:0] ACCL_YZ_MASK  = 16'h3fff;
  localparam int          NCH           = 6;
  localparam int          NGYRO         = 3;
  localparam int          EST_CNT_W     = 18;
  localparam int          EST_ACC_W     = 34;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_WAIT = 3'b100
  } bfb_state_t;

  // Saturating sum of a sample and its correction.
  function automatic logic signed [15:0] bfb_sat_add(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15]) begin
      bfb_sat_add = s[16] ? 16'sh8000 : 16'sh7fff;
    end else begin
      bfb_sat_add = s[15:0];
    end
  endfunction

  // Saturating negation, so that the most negative estimate still corrects.
  function automatic logic signed [15:0] bfb_sat_neg(input logic signed [15:0] a);
    bfb_sat_neg = (a == 16'sh8000) ? 16'sh7fff : -a;
  endfunction

endpackage

// File: rtl/bfb_filt_if.sv
// Interface carrying samples, settings and results between the top block and the averaging filter.
interface bfb_filt_if #(
  parameter int NCH = 6,
  parameter int W   = 16
);
  logic                tick;
  logic                clr;
  logic [2:0]          size;
  logic signed [W-1:0] din  [NCH];
  logic signed [W-1:0] dout [NCH];
  logic                dvalid;

  modport ctrl (output tick, output clr, output size, output din, input dout, input dvalid);
  modport filt (input tick, input clr, input size, input din, output dout, output dvalid);
endinterface

// File: rtl/bfb_avg_filter.sv
// Two cascaded running-average stages per channel, forming a triangular window filter.
module bfb_avg_filter
  import bfb_pkg::*;
#(
  parameter int NCH   = 6,
  parameter int W     = 16,
  parameter int MAXB  = 6
) (
  input  wire logic i_ref_clk,  // 200 MHz clock
  input  wire logic i_rst_b,    // Asynchronous reset, active low
  bfb_filt_if.filt  f           // Samples in, filtered samples out
);

  localparam int DEPTH = 1 << MAXB;
  localparam int SUM_W = W + MAXB;

  // ---------------------------------------------------------------
  // Shared history pointer and fill level
  // ---------------------------------------------------------------
  logic [MAXB-1:0] ptr_q;
  logic [MAXB:0]   fill_q;
  logic [MAXB:0]   taps;
  logic            full;
  logic [MAXB-1:0] old_idx;

  assign taps    = (MAXB+1)'(1) << f.size;                 // R2
  assign full    = (fill_q >= taps);
  assign old_idx = ptr_q - taps[MAXB-1:0];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q  <= '0;
      fill_q <= '0;
    end else if (f.clr) begin
      ptr_q  <= '0;
      fill_q <= '0;
    end else if (f.tick) begin
      ptr_q  <= ptr_q + 1'b1;
      fill_q <= full ? fill_q : fill_q + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      f.dvalid <= 1'b0;
    end else begin
      f.dvalid <= f.tick & ~f.clr;
    end
  end

  // ---------------------------------------------------------------
  // Per channel, per stage running sums
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [W-1:0]     hist [2][DEPTH];
    logic signed [SUM_W-1:0] sum_q [2];
    logic signed [W-1:0]     avg [2];
    logic signed [W-1:0]     stage_in [2];

    assign stage_in[0] = f.din[c];
    assign stage_in[1] = avg[0];                               // R1
    assign f.dout[c]   = avg[1];

    for (genvar s = 0; s < 2; s++) begin : g_stage
      logic signed [SUM_W-1:0] sub;
      assign avg[s] = W'(sum_q[s] >>> f.size);                 // R16
      assign sub    = full ? SUM_W'(hist[s][old_idx]) : '0;

      always_ff @(posedge i_ref_clk) begin
        if (f.tick) begin
          hist[s][ptr_q] <= stage_in[s];
        end
      end

      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          sum_q[s] <= '0;
        end else if (f.clr) begin
          sum_q[s] <= '0;
        end else if (f.tick) begin
          sum_q[s] <= sum_q[s] + SUM_W'(stage_in[s]) - sub;   // R16
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_fill_bounded: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R16
    fill_q <= taps || $changed(f.size) || $past(f.clr))
    else $error("Filter history fill exceeds the tap count.");

  a_stage_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R16
    f.clr |=> (fill_q == '0) && (g_ch[0].sum_q[0] == '0) && (g_ch[0].sum_q[1] == '0))
    else $error("Filter clear did not empty the averaging stages.");

endmodule // bfb_avg_filter

// File: tb/bfb_host.sv
// Host processor model that sends register byte frames and collects read answers.
module bfb_host (
  input  wire logic        i_ref_clk,   // Bench clock
  input  wire logic        i_rd_vld,    // Read answer strobe
  input  wire logic [15:0] i_rd_data,   // Read answer word
  output logic             o_frame_vld, // Frame strobe
  output logic      [15:0] o_frame      // Frame word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_frame_vld = 1'b0;
    o_frame     = 16'h0000;
  end

  // ---------------------------------------------------------------
  // Frame tasks
  // ---------------------------------------------------------------
  // The frame word is inverted once released, so a design that samples it late sees garbage.
  task automatic send(input logic [15:0] fr);
    @(negedge i_ref_clk);
    o_frame_vld = 1'b1;
    o_frame     = fr;
    @(negedge i_ref_clk);
    o_frame_vld = 1'b0;
    o_frame     = ~fr;
  endtask

  task automatic write_word(input logic [6:0] a, input logic [15:0] d);
    send({1'b1, a | 7'h01, d[15:8]});
    send({1'b1, a & 7'h7e, d[7:0]});
  endtask

  task automatic read_word(input logic [6:0] a, output logic [15:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d  = 16'h0000;
    send({1'b0, a, 8'h00});
    for (n = 0; n < 3 && !ok; n++) begin
      if (i_rd_vld === 1'b1) begin
        d  = i_rd_data;
        ok = 1'b1;
      end else begin
        @(negedge i_ref_clk);
      end
    end
  endtask
endmodule // bfb_host

// File: tb/tb.sv
// Self-checking bench of the filter and bias block against a register and data model.
module tb
  import bfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] OFFA [NCH] = '{GYRO_X_ADDR, GYRO_Y_ADDR, GYRO_Z_ADDR,
                                        ACCL_X_ADDR, ACCL_Y_ADDR, ACCL_Z_ADDR};

  logic        i_ref_clk = 1'b0;
  logic        i_rst_b;
  logic        tick;
  logic [15:0] raw  [NCH];
  logic [15:0] outs [NCH];
  logic        rd_vld;
  logic [15:0] rd_data;
  logic        frame_vld;
  logic [15:0] frame;
  logic        data_ready;
  int          error_cnt;
  int          total_checks;
  int          dr_cnt;
  logic [15:0] mdl [logic [6:0]];

  always #2.5 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    if (data_ready === 1'b1) begin
      dr_cnt++;
    end
  end

  bfb_top bfb_top_i (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_frame_vld(frame_vld), .i_frame(frame),
    .o_rd_vld(rd_vld), .o_rd_data(rd_data), .i_sample_tick(tick),
    .i_gyro_x(raw[0]), .i_gyro_y(raw[1]), .i_gyro_z(raw[2]),
    .i_accl_x(raw[3]), .i_accl_y(raw[4]), .i_accl_z(raw[5]),
    .o_gyro_x(outs[0]), .o_gyro_y(outs[1]), .o_gyro_z(outs[2]),
    .o_accl_x(outs[3]), .o_accl_y(outs[4]), .o_accl_z(outs[5]), .o_data_ready(data_ready)
  );

  bfb_host bfb_host_i (
    .i_ref_clk(i_ref_clk), .i_rd_vld(rd_vld), .i_rd_data(rd_data),
    .o_frame_vld(frame_vld), .o_frame(frame)
  );

  // ---------------------------------------------------------------
  // Model helpers and compare tasks
  // ---------------------------------------------------------------
  function automatic logic [15:0] sat16(input int v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return 16'(v);
  endfunction

  // The two upper accel y/z bits are unused, so the correction sign comes from bit 13.
  function automatic int off_val(input logic [6:0] a);
    if (a == ACCL_Y_ADDR || a == ACCL_Z_ADDR) return int'($signed(mdl[a][13:0]));
    return int'($signed(mdl[a]));
  endfunction

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    logic [2:0] s;
    logic [2:0] e;
    s = (d[2:0] > FIELD_MAX) ? FIELD_MAX : d[2:0];
    e = (d[10:8] > FIELD_MAX) ? FIELD_MAX : d[10:8];
    case (a)
      FILT_CTRL_ADDR: mdl[a] = {5'h00, e, 5'h00, s};
      ACCL_Y_ADDR, ACCL_Z_ADDR: mdl[a] = d & ACCL_YZ_MASK;
      DEC_SET_ADDR: mdl[a] = {5'h00, d[10:0]};
      default: mdl[a] = d;
    endcase
    bfb_host_i.write_word(a, d);
  endtask

  task automatic reg_rd(input logic [6:0] a);
    logic [15:0] d;
    bit          ok;
    bfb_host_i.read_word(a, d, ok);
    if (!ok) begin
      error_cnt++;
      finish_test();
    end else begin
      chk_word("register read", mdl.exists(a) ? mdl[a] : 16'h0000, d);
    end
  endtask

  task automatic smp(input int n);
    repeat (n) begin
      @(negedge i_ref_clk);
      tick = 1'b1;
      @(negedge i_ref_clk);
      tick = 1'b0;
      repeat (3) @(negedge i_ref_clk);
    end
  endtask

  // Inputs are held constant before this is called, so every filter length settles on the input.
  task automatic chk_outs();
    int i;
    for (i = 0; i < NCH; i++) begin
      chk_word("output word", sat16(int'($signed(raw[i])) + off_val(OFFA[i])), outs[i]);
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    #400us;
    error_cnt++;
    finish_test();
  end

  initial begin
    int b;
    int i;
    int g;
    error_cnt    = 0;
    total_checks = 0;
    dr_cnt       = 0;
    i_rst_b      = 1'b0;
    tick         = 1'b0;
    for (i = 0; i < NCH; i++) begin
      raw[i]       = 16'h0000;
      mdl[OFFA[i]] = OFF_RST;
    end
    mdl[FILT_CTRL_ADDR] = FLTR_RST;
    mdl[DEC_SET_ADDR]   = {5'h00, DEC_RST};
    void'($urandom(94529));
    repeat (12) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    reg_rd(FILT_CTRL_ADDR);
    reg_rd(7'h50);
    for (i = 0; i < NCH; i++) begin
      reg_rd(OFFA[i]);
      reg_wr(OFFA[i], 16'($urandom));
      reg_rd(OFFA[i]);
    end
    reg_wr(FILT_CTRL_ADDR, 16'h0707);
    reg_rd(FILT_CTRL_ADDR);
    for (b = 0; b <= 6; b++) begin
      reg_wr(FILT_CTRL_ADDR, 16'(b));
      reg_rd(FILT_CTRL_ADDR);
      for (i = 0; i < NCH; i++) begin
        raw[i] = 16'($urandom_range(4095));
      end
      smp((2 << b) + 3);
      chk_outs();
    end
    reg_wr(DEC_SET_ADDR, 16'h0003);
    reg_rd(DEC_SET_ADDR);
    dr_cnt = 0;
    smp(16);
    chk_cnt("ready pulses", 4, dr_cnt);
    reg_wr(DEC_SET_ADDR, 16'h0000);
    g = int'($urandom_range(2000)) - 1000;
    for (i = 0; i < NGYRO; i++) begin
      raw[i] = 16'(g);
    end
    smp(4100);
    bfb_host_i.send({1'b1, CMD_REG_ADDR, 8'h01});
    dr_cnt = 0;
    smp(1);
    chk_cnt("ready pulses", 0, dr_cnt);
    for (i = 0; i < NGYRO; i++) begin
      mdl[OFFA[i]] = 16'(-g);
      reg_rd(OFFA[i]);
    end
    smp(3);
    chk_outs();
    finish_test();
  end
endmodule // tb
